// File: logic/io_sched_map.svh
// Offsets, field positions, reset values and timing counts of the scheduler.
// Assumes a 100 MHz pclk; included by both ends and the interface.
`ifndef IO_SCHED_MAP_SVH
`define IO_SCHED_MAP_SVH
`define CLK_NS 10
`define TICK_US 10
`define TICK_CYC ((`TICK_US * 1000) / `CLK_NS)
`define SAMPLE_MIN_TICKS 30
`define SAMPLE_MAX_TICKS 2500
`define SAMPLE_RST_TICKS 100
`define PI_RST_TICKS 500
`define N_IN 4
`define N_OUT 2
`define CH_W 16
`define KEY_W 16
`define KEY_RST 16'h5a5a
`define REG_CTRL 12'h000
`define REG_SAMPLE 12'h004
`define REG_PI 12'h008
`define REG_STATUS 12'h00c
`define REG_KEY 12'h010
`define REG_OUT0 12'h014
`define REG_OUT1 12'h018
`define REG_IN0 12'h020
`define CTRL_CONNECT 0
`define CTRL_LISTEN 1
`define CTRL_DROP 2
`define CTRL_CAL 3
`define ST_OWNED 0
`define ST_REJECT 1
`define ST_FAULT 2
`define ST_LISTEN 3
`define ST_PRESENT 4
`endif

// File: logic/io_sched_pkg.sv
// Types shared by both ends of the scheduler link.
// Assumes the map header for the channel and key widths; command and state codes are literal.
`include "io_sched_map.svh"
package io_sched_pkg;
    typedef logic [`CH_W-1:0] chan_t;
    typedef logic [`KEY_W-1:0] key_t;
    typedef enum logic [2:0] {
        CMD_NONE = 3'h0,
        CMD_PROBE = 3'h1,
        CMD_CONFIG = 3'h2,
        CMD_OUTPUT = 3'h3,
        CMD_LISTEN = 3'h4,
        CMD_DROP = 3'h5
    } cmd_e;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_OWNED = 2'b01,
        ST_REJECTED = 2'b11
    } conn_e;
endpackage

// File: logic/io_sched_if.sv
// Backplane link between owner controller and the analog I/O scheduler.
// Single clock; commands and multicasts are one-cycle valid pulses.
`timescale 1ns/100ps
`include "io_sched_map.svh"
interface io_sched_if (
    input wire logic pclk,
    input wire logic presetn
);
    import io_sched_pkg::*;
    cmd_e cmd;
    logic cmd_valid;
    logic [31:0] cmd_data;
    logic [`KEY_W-1:0] cmd_key;
    logic present;
    logic ack;
    logic nak;
    logic mc_valid;
    logic mc_fresh;
    logic [`N_IN*`CH_W-1:0] mc_in;
    logic [`N_OUT*`CH_W-1:0] mc_echo;
    logic mc_listen;
    modport owner (output cmd, cmd_valid, cmd_data, cmd_key,
        input present, ack, nak, mc_valid, mc_fresh, mc_in, mc_echo,
        mc_listen);
    modport device (input cmd, cmd_valid, cmd_data, cmd_key,
        output present, ack, nak, mc_valid, mc_fresh, mc_in, mc_echo,
        mc_listen);
endinterface

// File: logic/io_sched_device.sv
// Scheduler of a four-input, two-output analog I/O module.
// Assumes owner commands on the link and sampled channel data on adc_data.
//
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "io_sched_map.svh"
module io_sched_device #(
    parameter int LOSS_TICKS = 1000,
    parameter int TICK_CYCLES = `TICK_CYC,
    parameter logic [`KEY_W-1:0] DEV_KEY = `KEY_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    io_sched_if.device link,
    input wire logic [`N_IN*`CH_W-1:0] adc_data,
    input wire logic cal_mode,
    output logic [`N_OUT*`CH_W-1:0] dac_data,
    output logic owned,
    output logic listening
);
    import io_sched_pkg::*;
    if (LOSS_TICKS < 2 || LOSS_TICKS > 65535) begin : g_bad_loss
        $error("LOSS_TICKS out of range");
    end
    // The prescaler is 16 bits wide
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end
    typedef struct packed {
        conn_e conn;
        logic listen;
        logic [15:0] sample_ticks;
        logic [15:0] pi_ticks;
        logic [15:0] pre;
        logic [15:0] sample_cnt;
        logic [15:0] pi_cnt;
        logic [15:0] loss_cnt;
        logic [`N_IN*`CH_W-1:0] mem_in;
        logic [`N_OUT*`CH_W-1:0] echo;
        logic [`N_OUT*`CH_W-1:0] dac;
        logic mc_valid;
        logic mc_fresh;
        logic ack;
        logic nak;
    } dev_s;
    dev_s r;
    dev_s next_r;
    logic tick;
    logic sample_due;
    logic pi_due;
    logic cfg_ok;
    logic [15:0] cfg_sample;
    logic [15:0] cfg_pi;
    always_comb begin
        next_r = r;
        next_r.ack = 1'b0;
        next_r.nak = 1'b0;
        next_r.mc_valid = 1'b0;
        next_r.mc_fresh = 1'b0;
        cfg_sample = link.cmd_data[15:0];
        cfg_pi = link.cmd_data[31:16];
        // Key compare and range check decide acceptance
        cfg_ok = link.cmd_key == DEV_KEY
            && cfg_sample >= 16'(`SAMPLE_MIN_TICKS)
            && cfg_sample <= 16'(`SAMPLE_MAX_TICKS)
            && cfg_pi != 16'h0000;
        tick = r.pre == 16'(TICK_CYCLES - 1);
        next_r.pre = tick ? 16'h0000 : r.pre + 16'h0001;
        sample_due = 1'b0;
        pi_due = 1'b0;
        if (r.conn == ST_OWNED && tick) begin
            next_r.sample_cnt = r.sample_cnt + 16'h0001;
            next_r.pi_cnt = r.pi_cnt + 16'h0001;
            if (r.sample_cnt + 16'h0001 >= r.sample_ticks) begin
                next_r.sample_cnt = 16'h0000;
                sample_due = !cal_mode;
            end
            if (r.pi_cnt + 16'h0001 >= r.pi_ticks) begin
                next_r.pi_cnt = 16'h0000;
                pi_due = 1'b1;
            end
            // Owner silence beyond the limit counts as a lost connection
            next_r.loss_cnt = r.loss_cnt + 16'h0001;
        end
        // Self-timed pushes, no poll command exists
        if (sample_due) begin
            next_r.mem_in = adc_data;
            next_r.mc_valid = 1'b1;
            next_r.mc_fresh = 1'b1;
        end else if (pi_due
            && (cal_mode || r.pi_ticks <= r.sample_ticks)) begin
            // A long interval would only resend stale data
            next_r.mc_valid = 1'b1;
        end
        if (link.cmd_valid) begin
            case (link.cmd)
                CMD_CONFIG: begin
                    // A second owner is refused while one holds the slot
                    if (r.conn != ST_OWNED && cfg_ok) begin
                        next_r.conn = ST_OWNED;
                        next_r.sample_ticks = cfg_sample;
                        next_r.pi_ticks = cfg_pi;
                        next_r.sample_cnt = 16'h0000;
                        next_r.pi_cnt = 16'h0000;
                        next_r.loss_cnt = 16'h0000;
                        next_r.ack = 1'b1;
                    end else begin
                        if (r.conn != ST_OWNED)
                            next_r.conn = ST_REJECTED;
                        next_r.nak = 1'b1;
                    end
                end
                CMD_OUTPUT: begin
                    if (r.conn == ST_OWNED) begin
                        next_r.dac = link.cmd_data;
                        next_r.echo = link.cmd_data;
                        next_r.loss_cnt = 16'h0000;
                        next_r.ack = 1'b1;
                    end else begin
                        next_r.nak = 1'b1;
                    end
                end
                CMD_LISTEN: begin
                    next_r.listen = r.conn == ST_OWNED;
                    next_r.ack = r.conn == ST_OWNED;
                    next_r.nak = r.conn != ST_OWNED;
                end
                CMD_DROP: begin
                    next_r.conn = ST_IDLE;
                    next_r.listen = 1'b0;
                    next_r.ack = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // Loss ends all multicasts and listeners
        if (r.conn == ST_OWNED
            && r.loss_cnt >= 16'(LOSS_TICKS)) begin
            next_r.conn = ST_IDLE;
            next_r.listen = 1'b0;
            next_r.mc_valid = 1'b0;
            next_r.mc_fresh = 1'b0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.conn <= ST_IDLE;
            r.sample_ticks <= 16'(`SAMPLE_RST_TICKS);
            r.pi_ticks <= 16'(`PI_RST_TICKS);
        end else begin
            r <= next_r;
        end
    end
    assign link.present = 1'b1;
    assign link.ack = r.ack;
    assign link.nak = r.nak;
    assign link.mc_valid = r.mc_valid;
    assign link.mc_fresh = r.mc_fresh;
    assign link.mc_in = r.mem_in;
    assign link.mc_echo = r.echo;
    assign link.mc_listen = r.listen;
    assign dac_data = r.dac;
    assign owned = r.conn == ST_OWNED;
    assign listening = r.listen;
endmodule

// File: logic/io_sched_owner.sv
// Owner controller end: APB registers drive the link to the I/O scheduler.
// Assumes an APB master on pclk; slave answers with pready always high.
`timescale 1ns/100ps
`include "io_sched_map.svh"
module io_sched_owner #(
    parameter int TICK_CYCLES = `TICK_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    io_sched_if.owner link
);
    import io_sched_pkg::*;
    if (TICK_CYCLES < 2 || TICK_CYCLES > 65536) begin : g_bad_tick
        $error("TICK_CYCLES out of range");
    end
    typedef struct packed {
        logic [15:0] sample_ticks;
        logic [15:0] pi_ticks;
        logic [`KEY_W-1:0] key;
        logic [`N_OUT*`CH_W-1:0] out;
        logic [`N_IN*`CH_W-1:0] in;
        logic [`N_OUT*`CH_W-1:0] echo;
        logic owned;
        logic reject;
        logic fault;
        logic listen;
        logic want;
        logic cfg_sent;
        logic [15:0] pi_cnt;
        logic [15:0] pre;
        cmd_e cmd;
        logic cmd_valid;
        logic [31:0] cmd_data;
        logic [31:0] rdata;
    } own_s;
    own_s r;
    own_s next_r;
    logic wr;
    logic rd;
    logic tick;
    function automatic logic [31:0] read_reg(input own_s s,
        input logic [11:0] a);
        if (a == `REG_SAMPLE) read_reg = {16'h0000, s.sample_ticks};
        else if (a == `REG_PI) read_reg = {16'h0000, s.pi_ticks};
        else if (a == `REG_STATUS)
            read_reg = {27'h0, link.present, s.listen, s.fault,
                s.reject, s.owned};
        else if (a == `REG_KEY) read_reg = {16'h0000, s.key};
        else if (a == `REG_OUT0) read_reg = {16'h0000, s.out[15:0]};
        else if (a == `REG_OUT1) read_reg = {16'h0000, s.out[31:16]};
        else if (a == `REG_IN0) read_reg = s.in[31:0];
        else if (a == `REG_IN0 + 12'h004) read_reg = s.in[63:32];
        else if (a == `REG_IN0 + 12'h008) read_reg = s.echo;
        else read_reg = 32'h00000000;
    endfunction
    always_comb begin
        next_r = r;
        next_r.cmd_valid = 1'b0;
        next_r.cmd = CMD_NONE;
        wr = psel && penable && pwrite;
        rd = psel && !penable && !pwrite;
        if (rd) next_r.rdata = read_reg(r, paddr);
        if (wr) begin
            if (paddr == `REG_CTRL) begin
                if (pwdata[`CTRL_CONNECT]) begin
                    next_r.want = 1'b1;
                    next_r.cfg_sent = 1'b0;
                    next_r.reject = 1'b0;
                end
                if (pwdata[`CTRL_LISTEN]) begin
                    next_r.cmd = CMD_LISTEN;
                    next_r.cmd_valid = 1'b1;
                end
                if (pwdata[`CTRL_DROP]) begin
                    next_r.want = 1'b0;
                    next_r.owned = 1'b0;
                    next_r.cmd = CMD_DROP;
                    next_r.cmd_valid = 1'b1;
                end
            end else if (paddr == `REG_SAMPLE) begin
                next_r.sample_ticks = pwdata[15:0];
            end else if (paddr == `REG_PI) begin
                next_r.pi_ticks = pwdata[15:0];
            end else if (paddr == `REG_KEY) begin
                next_r.key = pwdata[`KEY_W-1:0];
            end else if (paddr == `REG_OUT0) begin
                next_r.out[15:0] = pwdata[15:0];
            end else if (paddr == `REG_OUT1) begin
                next_r.out[31:16] = pwdata[15:0];
            end else if (paddr == `REG_STATUS) begin
                next_r.fault = r.fault && !pwdata[`ST_FAULT];
            end
        end
        tick = r.pre == 16'(TICK_CYCLES - 1);
        next_r.pre = tick ? 16'h0000 : r.pre + 16'h0001;
        // Check link.present, then send configuration once
        if (r.want && !r.owned && !r.cfg_sent && link.present
            && !next_r.cmd_valid) begin
            next_r.cmd = CMD_CONFIG;
            next_r.cmd_valid = 1'b1;
            next_r.cmd_data = {r.pi_ticks, r.sample_ticks};
            next_r.cfg_sent = 1'b1;
        end
        if (link.ack && r.cfg_sent && !r.owned && r.want) begin
            next_r.owned = 1'b1;
            next_r.pi_cnt = 16'h0000;
        end
        if (link.nak && r.cfg_sent && !r.owned) next_r.reject = 1'b1;
        // Outputs go out only on the interval
        if (r.owned && tick) begin
            next_r.pi_cnt = r.pi_cnt + 16'h0001;
            if (r.pi_cnt + 16'h0001 >= r.pi_ticks
                && !next_r.cmd_valid) begin
                next_r.pi_cnt = 16'h0000;
                next_r.cmd = CMD_OUTPUT;
                next_r.cmd_valid = 1'b1;
                next_r.cmd_data = r.out;
            end
        end
        // Inputs arrive unasked
        if (link.mc_valid) begin
            next_r.in = link.mc_in;
            next_r.echo = link.mc_echo;
        end
        next_r.listen = link.mc_listen;
        // Broken connection sets a sticky fault
        if (r.owned && !link.present) begin
            next_r.owned = 1'b0;
            next_r.fault = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
            r.sample_ticks <= 16'(`SAMPLE_RST_TICKS);
            r.pi_ticks <= 16'(`PI_RST_TICKS);
            r.key <= `KEY_RST;
            r.cmd <= CMD_NONE;
        end else begin
            r <= next_r;
        end
    end
    assign prdata = r.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign link.cmd = r.cmd;
    assign link.cmd_valid = r.cmd_valid;
    assign link.cmd_data = r.cmd_data;
    assign link.cmd_key = r.key;
endmodule

// File: verif/io_sched_properties.sv
// Checker for the scheduler link: timing relations between owner and device.
// Assumes the link signals as plain inputs, one clock, async low reset.
`include "io_sched_map.svh"
`timescale 1ns/100ps
module io_sched_properties
    import io_sched_pkg::*;
#(
    parameter logic [`KEY_W-1:0] DEV_KEY = `KEY_RST
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire io_sched_pkg::cmd_e cmd,
    input wire logic cmd_valid,
    input wire logic [31:0] cmd_data,
    input wire logic [`KEY_W-1:0] cmd_key,
    input wire logic present,
    input wire logic ack,
    input wire logic nak,
    input wire logic mc_valid,
    input wire logic mc_fresh,
    input wire logic [`N_IN*`CH_W-1:0] mc_in,
    input wire logic [`N_OUT*`CH_W-1:0] mc_echo,
    input wire logic mc_listen
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_fresh_valid;
        mc_fresh |-> mc_valid;
    endproperty
    a_fresh_valid: assert property (p_fresh_valid)
        else $error("fresh flag without multicast");
    property p_in_hold;
        !mc_fresh |-> $stable(mc_in);
    endproperty
    a_in_hold: assert property (p_in_hold)
        else $error("input data changed without a sample event");
    // Coinciding timers must merge, so two pulses in a row are a fault
    property p_single_mc;
        mc_valid |=> !mc_valid;
    endproperty
    a_single_mc: assert property (p_single_mc)
        else $error("two multicasts in consecutive cycles");
    property p_answer;
        cmd_valid |=> (ack ^ nak);
    endproperty
    a_answer: assert property (p_answer)
        else $error("command not answered by exactly one of ack and nak");
    property p_answer_cause;
        (ack || nak) |-> $past(cmd_valid);
    endproperty
    a_answer_cause: assert property (p_answer_cause)
        else $error("answer without a command");
    property p_bad_key;
        cmd_valid && cmd == CMD_CONFIG && cmd_key != DEV_KEY |=> nak;
    endproperty
    a_bad_key: assert property (p_bad_key)
        else $error("configuration with wrong key accepted");
    property p_bad_range;
        cmd_valid && cmd == CMD_CONFIG
            && (cmd_data[15:0] < `SAMPLE_MIN_TICKS
            || cmd_data[15:0] > `SAMPLE_MAX_TICKS) |=> nak;
    endproperty
    a_bad_range: assert property (p_bad_range)
        else $error("sample period out of range accepted");
    property p_drop_quiet;
        cmd_valid && cmd == CMD_DROP ##1 ack |=> ##1
            (!mc_valid && !mc_listen) [*8];
    endproperty
    a_drop_quiet: assert property (p_drop_quiet)
        else $error("multicast or listener after owner loss");
    property p_echo_cause;
        $changed(mc_echo) |-> $past(cmd_valid) || $past(cmd_valid, 2);
    endproperty
    a_echo_cause: assert property (p_echo_cause)
        else $error("echo changed without an output command");
    property p_listen_cause;
        $rose(mc_listen) |-> ack || $past(ack) || $past(ack, 2);
    endproperty
    a_listen_cause: assert property (p_listen_cause)
        else $error("listener joined without an accepted command");
endmodule

// File: verif/io_multicast_scheduler_tb.sv
// Bench for the scheduler: owner and device joined on one link.
// Assumes the design files and map header are compiled before it.
`include "io_sched_map.svh"
`timescale 1ns/100ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin \
    n_mismatch++; $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module io_multicast_scheduler_tb;
    import io_sched_pkg::*;
    // Short tick keeps the run short; only period ratios matter here
    localparam int T = 10;
    typedef struct {int s; int p; logic cal; logic [31:0] outw;} row_s;
    // Sample ticks, interval ticks, calibration, output words
    row_s rows[3] = '{'{30, 10, 1'b0, 32'h8765_1234},
        '{30, 40, 1'b0, 32'h0001_ffff}, '{30, 10, 1'b1, 32'h7fff_8000}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cal_mode;
    logic dev_owned, dev_listening;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [`N_IN*`CH_W-1:0] adc_data;
    logic [`N_OUT*`CH_W-1:0] dac_data;
    int n_mismatch, check_count, nm, nf, gmax, fgap, bad_in;

    io_sched_if link_if (.pclk(pclk), .presetn(presetn));
    // Loss limit above the longest row interval (40 ticks), so rows never time out
    io_sched_device #(.LOSS_TICKS(60), .TICK_CYCLES(T)) u_io_sched_device (
        .pclk(pclk), .presetn(presetn),
        .link(link_if), .adc_data(adc_data), .cal_mode(cal_mode),
        .dac_data(dac_data), .owned(dev_owned), .listening(dev_listening));
    io_sched_owner #(.TICK_CYCLES(T)) u_io_sched_owner (
        .pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link_if));
    io_sched_properties u_chk (.pclk(pclk), .presetn(presetn),
        .cmd(link_if.cmd), .cmd_valid(link_if.cmd_valid),
        .cmd_data(link_if.cmd_data), .cmd_key(link_if.cmd_key),
        .present(link_if.present), .ack(link_if.ack), .nak(link_if.nak),
        .mc_valid(link_if.mc_valid), .mc_fresh(link_if.mc_fresh),
        .mc_in(link_if.mc_in), .mc_echo(link_if.mc_echo),
        .mc_listen(link_if.mc_listen));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // Inputs move every cycle, so a resampled multicast cannot hide
    always @(posedge pclk) begin
        adc_data <= adc_data + 64'h0001_0002_0003_0004;
    end

    task automatic test_done();
        $display("Checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i <= 16; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
            if (i == 16) begin
                n_mismatch++;
                test_done();
            end
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Wait lengths differ between connect, listen and loss, so the bound is generous
    task automatic wait_for(input int which, input logic want);
        for (int i = 0; i <= 30000; i++) begin
            @(negedge pclk);
            if ((which == 0 ? dev_owned : dev_listening) === want) break;
            if (i == 30000) begin
                n_mismatch++;
                $display("[FAIL] wait %0d timed out", which);
                test_done();
            end
        end
    endtask

    task automatic observe(input int cyc);
        int lm;
        int lf;
        logic [`N_IN*`CH_W-1:0] last_in;
        lm = -1;
        lf = -1;
        {nm, nf, gmax, fgap, bad_in} = '0;
        for (int c = 0; c < cyc; c++) begin
            @(negedge pclk);
            if (link_if.mc_valid === 1'b1) begin
                if (lm >= 0 && c - lm > gmax) gmax = c - lm;
                lm = c;
                nm++;
                if (link_if.mc_fresh === 1'b1) begin
                    if (lf >= 0) fgap = c - lf;
                    lf = c;
                    nf++;
                    last_in = link_if.mc_in;
                end else if (lf >= 0 && link_if.mc_in !== last_in) begin
                    bad_in++;
                end
            end
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, cal_mode} = '0;
        paddr = '0;
        pwdata = '0;
        adc_data = '0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `REG_SAMPLE, 32'h0);
        `CHK("sample reset", 32'd100, rd)
        apb(1'b0, `REG_PI, 32'h0);
        `CHK("interval reset", 32'd500, rd)
        apb(1'b0, `REG_KEY, 32'h0);
        `CHK("key reset", 32'h5a5a, rd)
        apb(1'b0, 12'h0fc, 32'h0);
        `CHK("unmapped read", 32'h0, rd)
        apb(1'b0, `REG_STATUS, 32'h0);
        `CHK("status reset", 32'h10, rd)
        $display("Test reset done");
        foreach (rows[r]) begin
            cal_mode <= rows[r].cal;
            apb(1'b1, `REG_SAMPLE, rows[r].s);
            apb(1'b1, `REG_PI, rows[r].p);
            apb(1'b1, `REG_OUT0, {16'h0, rows[r].outw[15:0]});
            apb(1'b1, `REG_OUT1, {16'h0, rows[r].outw[31:16]});
            apb(1'b1, `REG_CTRL, 32'h1);
            wait_for(0, 1'b1);
            if (r == 0) begin
                apb(1'b1, `REG_CTRL, 32'h3);
                wait_for(1, 1'b1);
                `CHK("listener", 1'b1, link_if.mc_listen)
            end
            observe((2 * rows[r].s + rows[r].p) * T + 10);
            `CHK("fresh gap", rows[r].cal ? 0 : rows[r].s * T, fgap)
            `CHK("mc gap", (rows[r].cal || rows[r].p < rows[r].s) ?
                rows[r].p * T : rows[r].s * T, gmax)
            if (rows[r].cal) `CHK("no fresh", 0, nf)
            else if (rows[r].p > rows[r].s) `CHK("all fresh", nm, nf)
            `CHK("repeat inputs", 0, bad_in)
            `CHK("echo", rows[r].outw, link_if.mc_echo)
            `CHK("outputs", rows[r].outw, dac_data)
            apb(1'b1, `REG_CTRL, 32'h4);
            wait_for(0, 1'b0);
            wait_for(1, 1'b0);
            `CHK("listener drop", 1'b0, link_if.mc_listen)
            apb(1'b1, `REG_CTRL, 32'h0);
            $display("Test row %0d done", r);
        end
        // Owner goes quiet: a long owner interval starves the device
        cal_mode <= 1'b0;
        apb(1'b1, `REG_CTRL, 32'h1);
        wait_for(0, 1'b1);
        apb(1'b1, `REG_CTRL, 32'h2);
        wait_for(1, 1'b1);
        apb(1'b1, `REG_PI, 32'd200);
        wait_for(0, 1'b0);
        `CHK("loss listener", 1'b0, link_if.mc_listen)
        observe(20 * T);
        `CHK("loss quiet", 0, nm)
        apb(1'b1, `REG_CTRL, 32'h4);
        $display("Test loss done");
        // Bad key, then sample period just below and just above range
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, `REG_KEY, k == 0 ? 32'h1111 : 32'h5a5a);
            apb(1'b1, `REG_SAMPLE, k == 1 ? 29 : (k == 2 ? 2501 : 30));
            apb(1'b1, `REG_CTRL, 32'h1);
            for (int i = 0; i < 100; i++) begin
                apb(1'b0, `REG_STATUS, 32'h0);
                if (rd[`ST_REJECT] === 1'b1) break;
            end
            `CHK("reject", 1'b1, rd[`ST_REJECT])
            `CHK("not owned", 1'b0, dev_owned)
            apb(1'b1, `REG_CTRL, 32'h0);
            $display("Test reject %0d done", k);
        end
        test_done();
    end
endmodule
